// >>> src/ssq_top.sv
// Scan stream sequencer: scan clocking, triggering, sampling, overflow handling and registers
`timescale 1ns/1ps
`default_nettype none
// How it works
// RL1: Scans start only on the hardware scan tick, never from software directly.
// RL2: A tick during a running scan halts streaming with error code 2942.
// RL3: Samples wait in a device FIFO of up to 32768 bytes until read.
// RL4: FIFO size must be a power of two; zero means default size.
// RL5: FIFO size is latched at session start; later writes wait for next session.
// RL6: When full, scanning goes on but data is dropped until FIFO empties.
// RL7: Every scan that lost data is counted in a readable skipped counter.
// RL8: Overflow lasting past the timeout ends the stream with an error.
// RL9: Channels of the list are sampled in order, right after scan start.
// RL10: Pulse pin falls at scan start, rises per sample, falls after, rises at end.
// RL11: Burst mode stops on its own after the programmed scan count.
// RL12: Clock select 0 is internal, 2 is external pin, others reserved.
// RL13: External rising edges are counted; a scan starts when count meets divisor.
// RL14: The divisor is the number of external pulses per scan period.
// RL15: Trigger 0 starts at once; 2000-2003, 2006, 2007 wait for that channel's edge.
// RL16: Trigger edge is rising or falling by choice, or either edge.
// RL17: Without burst or trigger, scanning starts at once and repeats until stopped.
// RL18: Each stored sample is one 16-bit word, two bytes of capacity.
// RL19: After the trigger fires, further trigger edges are ignored until session end.
module ssq_top
  import ssq_pkg::*;
#(
  parameter int OVF_TIMEOUT_CYCLES = OVF_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Register access
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Pins
  input wire logic ext_scan_clock_pin,
  input wire logic [7:0] pin_feature_channel,
  output logic scan_timing_pulse_pin,
  // Sample source
  output logic samp_req,
  output logic [7:0] samp_chan,
  input wire logic samp_valid,
  input wire logic [15:0] samp_data
);
  ssq_fifo_if fif();

  ssq_fifo u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .fif(fif)
  );

  // Configuration and bus state
  logic [31:0] cap_r, cap_nxt;
  logic [31:0] clksel_r, clksel_nxt;
  logic [31:0] burst_r, burst_nxt;
  logic [31:0] div_r, div_nxt;
  logic [31:0] trig_r, trig_nxt;
  logic [31:0] period_r, period_nxt;
  logic [7:0] nch_r, nch_nxt;
  logic [1:0] edge_r, edge_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  // Sequencer state
  ssq_state_t state_r, state_nxt;
  logic [LVL_W-1:0] capw_r, capw_nxt;
  logic [31:0] done_r, done_nxt;
  logic [31:0] skipped_r, skipped_nxt;
  logic [15:0] err_r, err_nxt;
  logic ovf_r, ovf_nxt;
  logic drop_scan_r, drop_scan_nxt;
  logic [31:0] ovf_cnt_r, ovf_cnt_nxt;
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic [31:0] ext_cnt_r, ext_cnt_nxt;
  logic [7:0] chan_r, chan_nxt;
  logic pulse_r, pulse_nxt;
  logic ext_prev_r;
  logic [7:0] pf_prev_r;
  logic [15:0] push_data_r, push_data_nxt;
  logic push_r, push_nxt;
  // Decoded strobes
  logic start_cmd;
  logic stop_cmd;
  logic fifo_full;
  logic tick;
  logic trig_fire;
  logic trig_known;
  logic [2:0] trig_ch;
  logic ext_rise;
  logic pf_rise;
  logic pf_fall;
  logic [31:0] cap_bytes;

  assign start_cmd = reg_wr && (reg_addr == ADDR_CTL) && reg_wdata[0];
  assign stop_cmd = reg_wr && (reg_addr == ADDR_CTL) && !reg_wdata[0];
  assign fifo_full = fif.level >= capw_r;
  assign ext_rise = ext_scan_clock_pin && !ext_prev_r;
  assign cap_bytes = (cap_r == 32'h0000_0000) ? FIFO_DEF_BYTES : cap_r; // RL4

  // Trigger index decode: only the listed channels are accepted
  always_comb begin
    trig_ch = trig_r[2:0] - TRIG_BASE[2:0];
    trig_known = (trig_r >= TRIG_BASE) && (trig_r <= TRIG_BASE + 32'h0000_0007) &&
                 (trig_ch != 3'h4) && (trig_ch != 3'h5); // RL15
    pf_rise = pin_feature_channel[trig_ch] && !pf_prev_r[trig_ch];
    pf_fall = !pin_feature_channel[trig_ch] && pf_prev_r[trig_ch];
    case (edge_r) // RL16
      EDGE_RISE: trig_fire = trig_known && pf_rise;
      EDGE_FALL: trig_fire = trig_known && pf_fall;
      EDGE_BOTH: trig_fire = trig_known && (pf_rise || pf_fall);
      default: trig_fire = 1'b0;
    endcase
  end

  // Register writes and registered read answer
  always_comb begin
    cap_nxt = cap_r;
    clksel_nxt = clksel_r;
    burst_nxt = burst_r;
    div_nxt = div_r;
    trig_nxt = trig_r;
    period_nxt = period_r;
    nch_nxt = nch_r;
    edge_nxt = edge_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_rd;
    fif.pop = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_FIFO_CAP: begin
          // Non power-of-two or oversize values are ignored
          if ((reg_wdata == 32'h0000_0000) ||
              (ssq_is_pow2(reg_wdata) && reg_wdata >= 32'h0000_0002 && reg_wdata <= FIFO_MAX_BYTES)) begin
            cap_nxt = reg_wdata; // RL3 RL4
          end
        end
        ADDR_CLK_SEL: clksel_nxt = reg_wdata;
        ADDR_BURST: burst_nxt = reg_wdata;
        ADDR_EXT_DIV: div_nxt = reg_wdata;
        ADDR_TRIG: trig_nxt = reg_wdata;
        ADDR_PERIOD: period_nxt = reg_wdata;
        ADDR_NUM_CH: nch_nxt = reg_wdata[7:0];
        ADDR_EDGE: edge_nxt = reg_wdata[1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_FIFO_CAP: rdata_nxt = cap_r;
        ADDR_CLK_SEL: rdata_nxt = clksel_r;
        ADDR_BURST: rdata_nxt = burst_r;
        ADDR_EXT_DIV: rdata_nxt = div_r;
        ADDR_TRIG: rdata_nxt = trig_r;
        ADDR_PERIOD: rdata_nxt = period_r;
        ADDR_NUM_CH: rdata_nxt = {24'h000000, nch_r};
        ADDR_EDGE: rdata_nxt = {30'h00000000, edge_r};
        ADDR_CTL: rdata_nxt = {31'h00000000, state_r != SQ_IDLE};
        ADDR_STATUS: begin
          rdata_nxt = 32'h0000_0000;
          rdata_nxt[ST_RUN_BIT] = state_r != SQ_IDLE;
          rdata_nxt[ST_ARM_BIT] = state_r == SQ_ARM;
          rdata_nxt[ST_OVF_BIT] = ovf_r;
          rdata_nxt[ST_ERR_LSB +: 16] = err_r;
        end
        ADDR_DATA: begin
          // Reading the data register removes the word; empty reads as zero
          rdata_nxt = (fif.level != '0) ? {16'h0000, fif.rd_data} : 32'h0000_0000;
          fif.pop = 1'b1; // RL3
        end
        ADDR_BACKLOG: rdata_nxt = {16'h0000, fif.level, 1'b0}; // RL18
        ADDR_SKIPPED: rdata_nxt = skipped_r; // RL7
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cap_r <= RST_CAP;
      clksel_r <= RST_CLK_SEL;
      burst_r <= RST_BURST;
      div_r <= RST_DIV;
      trig_r <= RST_TRIG;
      period_r <= RST_PERIOD;
      nch_r <= RST_NUM_CH;
      edge_r <= RST_EDGE;
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else if (ce) begin
      cap_r <= cap_nxt;
      clksel_r <= clksel_nxt;
      burst_r <= burst_nxt;
      div_r <= div_nxt;
      trig_r <= trig_nxt;
      period_r <= period_nxt;
      nch_r <= nch_nxt;
      edge_r <= edge_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Scan sequencer: clocking, trigger, sampling, overflow and error handling
  always_comb begin
    state_nxt = state_r;
    capw_nxt = capw_r;
    done_nxt = done_r;
    skipped_nxt = skipped_r;
    err_nxt = err_r;
    ovf_nxt = ovf_r;
    drop_scan_nxt = drop_scan_r;
    ovf_cnt_nxt = ovf_r ? ovf_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    tick_cnt_nxt = tick_cnt_r;
    ext_cnt_nxt = ext_cnt_r;
    chan_nxt = chan_r;
    pulse_nxt = pulse_r;
    push_nxt = 1'b0;
    push_data_nxt = push_data_r;
    fif.clr = 1'b0;
    tick = 1'b0;
    // Scan tick only exists once the session is past its trigger
    if (state_r != SQ_IDLE && state_r != SQ_ARM) begin
      if (clksel_r == CLK_SEL_INT) begin // RL12
        if (tick_cnt_r == 32'h0000_0000) begin
          tick = 1'b1;
          tick_cnt_nxt = ssq_at_least_one(period_r) - 32'h0000_0001;
        end else begin
          tick_cnt_nxt = tick_cnt_r - 32'h0000_0001;
        end
      end else if (clksel_r == CLK_SEL_EXT && ext_rise) begin
        if (ext_cnt_r + 32'h0000_0001 >= ssq_at_least_one(div_r)) begin // RL13 RL14
          tick = 1'b1;
          ext_cnt_nxt = 32'h0000_0000;
        end else begin
          ext_cnt_nxt = ext_cnt_r + 32'h0000_0001;
        end
      end
    end
    case (state_r)
      SQ_IDLE: begin
        pulse_nxt = 1'b1;
        if (start_cmd) begin
          // Size is captured here so mid-session writes cannot disturb this run
          capw_nxt = cap_bytes[LVL_W:1]; // RL5 RL18
          fif.clr = 1'b1;
          done_nxt = 32'h0000_0000;
          skipped_nxt = 32'h0000_0000;
          err_nxt = ERR_NONE;
          ovf_nxt = 1'b0;
          ovf_cnt_nxt = 32'h0000_0000;
          tick_cnt_nxt = 32'h0000_0000;
          ext_cnt_nxt = 32'h0000_0000;
          state_nxt = (trig_r == TRIG_NONE) ? SQ_WAIT : SQ_ARM; // RL15 RL17
        end
      end
      SQ_ARM: begin
        // Leaving ARM for good means later edges are never looked at again
        if (trig_fire) begin
          state_nxt = SQ_WAIT; // RL15 RL19
          tick_cnt_nxt = 32'h0000_0000;
        end
      end
      SQ_WAIT: begin
        if (tick) begin
          state_nxt = SQ_START; // RL1
          pulse_nxt = 1'b0; // RL10
          chan_nxt = 8'h00;
          drop_scan_nxt = 1'b0;
          if (ovf_r && fif.level == '0) begin
            ovf_nxt = 1'b0; // RL6
          end
        end
      end
      SQ_START: begin
        state_nxt = SQ_SAMPLE; // RL9
        pulse_nxt = 1'b1; // RL10
      end
      SQ_SAMPLE: begin
        if (samp_valid) begin
          state_nxt = SQ_GAP;
          pulse_nxt = 1'b0; // RL10
          if (ovf_r || fifo_full) begin
            ovf_nxt = 1'b1; // RL6
            drop_scan_nxt = 1'b1;
          end else begin
            push_nxt = 1'b1; // RL18
            push_data_nxt = samp_data;
          end
        end
      end
      SQ_GAP: begin
        if ({24'h000000, chan_r} + 32'h0000_0001 < ssq_at_least_one({24'h000000, nch_r})) begin
          chan_nxt = chan_r + 8'h01; // RL9
          state_nxt = SQ_SAMPLE;
          pulse_nxt = 1'b1; // RL10
        end else begin
          pulse_nxt = 1'b1; // RL10
          done_nxt = done_r + 32'h0000_0001;
          if (drop_scan_r) begin
            skipped_nxt = skipped_r + 32'h0000_0001; // RL7
          end
          if (burst_r != 32'h0000_0000 && done_r + 32'h0000_0001 == burst_r) begin
            state_nxt = SQ_IDLE; // RL11
          end else begin
            state_nxt = SQ_WAIT; // RL17
          end
        end
      end
      default: state_nxt = SQ_IDLE;
    endcase
    // A tick landing inside a scan is fatal to the session
    if (tick && (state_r == SQ_START || state_r == SQ_SAMPLE || state_r == SQ_GAP)) begin
      state_nxt = SQ_IDLE; // RL2
      err_nxt = ERR_OVERLAP; // RL2
      pulse_nxt = 1'b1;
      push_nxt = 1'b0;
    end
    // Only a live session times out, so a stale flag in idle cannot swallow the next start
    if (state_r != SQ_IDLE && ovf_r && ovf_cnt_r >= 32'(OVF_TIMEOUT_CYCLES)) begin
      state_nxt = SQ_IDLE; // RL8
      err_nxt = ERR_OVF_TIMEOUT; // RL8
      pulse_nxt = 1'b1;
      push_nxt = 1'b0;
    end
    if (stop_cmd && state_r != SQ_IDLE) begin
      state_nxt = SQ_IDLE; // RL17
      pulse_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SQ_IDLE;
      capw_r <= '0;
      done_r <= 32'h0000_0000;
      skipped_r <= 32'h0000_0000;
      err_r <= ERR_NONE;
      ovf_r <= 1'b0;
      drop_scan_r <= 1'b0;
      ovf_cnt_r <= 32'h0000_0000;
      tick_cnt_r <= 32'h0000_0000;
      ext_cnt_r <= 32'h0000_0000;
      chan_r <= 8'h00;
      pulse_r <= 1'b1;
      ext_prev_r <= 1'b0;
      pf_prev_r <= 8'h00;
      push_r <= 1'b0;
      push_data_r <= 16'h0000;
    end else if (ce) begin
      state_r <= state_nxt;
      capw_r <= capw_nxt;
      done_r <= done_nxt;
      skipped_r <= skipped_nxt;
      err_r <= err_nxt;
      ovf_r <= ovf_nxt;
      drop_scan_r <= drop_scan_nxt;
      ovf_cnt_r <= ovf_cnt_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      ext_cnt_r <= ext_cnt_nxt;
      chan_r <= chan_nxt;
      pulse_r <= pulse_nxt;
      ext_prev_r <= ext_scan_clock_pin;
      pf_prev_r <= pin_feature_channel;
      push_r <= push_nxt;
      push_data_r <= push_data_nxt;
    end
  end

  // Push is registered one cycle behind the accepted sample
  assign fif.push = push_r;
  assign fif.push_data = push_data_r;
  assign samp_req = state_r == SQ_SAMPLE;
  assign samp_chan = chan_r;
  assign scan_timing_pulse_pin = pulse_r;
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
endmodule
`default_nettype wire

// >>> src/ssq_pkg.sv
// Constants, register map and types shared by the scan stream sequencer files
package ssq_pkg;
  // Register map, in register-protocol address units (two per 32-bit value)
  localparam logic [15:0] ADDR_FIFO_CAP = 16'h0FAC;
  localparam logic [15:0] ADDR_CLK_SEL = 16'h0FAE;
  localparam logic [15:0] ADDR_BURST = 16'h0FB4;
  localparam logic [15:0] ADDR_EXT_DIV = 16'h0FB6;
  localparam logic [15:0] ADDR_TRIG = 16'h0FB8;
  localparam logic [15:0] ADDR_CTL = 16'h1000;
  localparam logic [15:0] ADDR_STATUS = 16'h1002;
  localparam logic [15:0] ADDR_DATA = 16'h1004;
  localparam logic [15:0] ADDR_BACKLOG = 16'h1006;
  localparam logic [15:0] ADDR_SKIPPED = 16'h1008;
  localparam logic [15:0] ADDR_PERIOD = 16'h100A;
  localparam logic [15:0] ADDR_NUM_CH = 16'h100C;
  localparam logic [15:0] ADDR_EDGE = 16'h100E;

  // FIFO sizing: 16-bit samples, two bytes each
  localparam logic [31:0] FIFO_MAX_BYTES = 32'h0000_8000;
  localparam logic [31:0] FIFO_DEF_BYTES = 32'h0000_8000;
  localparam int FIFO_DEPTH = 16384;
  localparam int FIFO_AW = 14;
  localparam int LVL_W = 15;

  // Reset values
  localparam logic [31:0] RST_CAP = 32'h0000_0000;
  localparam logic [31:0] RST_CLK_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_BURST = 32'h0000_0000;
  localparam logic [31:0] RST_DIV = 32'h0000_0001;
  localparam logic [31:0] RST_TRIG = 32'h0000_0000;
  localparam logic [31:0] RST_PERIOD = 32'h0000_9C40;
  localparam logic [7:0] RST_NUM_CH = 8'h01;
  localparam logic [1:0] RST_EDGE = 2'h0;

  // Encodings
  localparam logic [31:0] CLK_SEL_INT = 32'h0000_0000;
  localparam logic [31:0] CLK_SEL_EXT = 32'h0000_0002;
  localparam logic [31:0] TRIG_NONE = 32'h0000_0000;
  localparam logic [31:0] TRIG_BASE = 32'h0000_07D0;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_OVERLAP = 16'h0B7E;
  // Value is arbitrary
  localparam logic [15:0] ERR_OVF_TIMEOUT = 16'h0FFF;

  // Status field positions
  localparam int ST_RUN_BIT = 0;
  localparam int ST_ARM_BIT = 1;
  localparam int ST_OVF_BIT = 2;
  localparam int ST_ERR_LSB = 16;

  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int OVF_TIMEOUT_MS = 1000;
  localparam int OVF_TIMEOUT_CYC = CLK_HZ / 1000 * OVF_TIMEOUT_MS;

  typedef enum logic [2:0] {SQ_IDLE, SQ_ARM, SQ_WAIT, SQ_START, SQ_SAMPLE, SQ_GAP} ssq_state_t;

  // A zero divisor or period behaves as one
  function automatic logic [31:0] ssq_at_least_one(input logic [31:0] v);
    return (v == 32'h0000_0000) ? 32'h0000_0001 : v;
  endfunction

  function automatic logic ssq_is_pow2(input logic [31:0] v);
    return (v != 32'h0000_0000) && ((v & (v - 32'h0000_0001)) == 32'h0000_0000);
  endfunction
endpackage

// >>> src/ssq_fifo_if.sv
// Interface between the sequencer control and its sample FIFO
`timescale 1ns/1ps
`default_nettype none
interface ssq_fifo_if;
  logic clr;
  logic push;
  logic pop;
  logic [15:0] push_data;
  logic [15:0] rd_data;
  logic [14:0] level;
  modport ctl (output clr, output push, output pop, output push_data, input rd_data, input level);
  modport mem (input clr, input push, input pop, input push_data, output rd_data, output level);
endinterface
`default_nettype wire

// >>> src/ssq_fifo.sv
// Sample FIFO of 16-bit words for the scan stream sequencer
`timescale 1ns/1ps
`default_nettype none
module ssq_fifo
  import ssq_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Control side
  ssq_fifo_if.mem fif
);
  logic [15:0] mem_a [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wp_r;
  logic [FIFO_AW-1:0] wp_nxt;
  logic [FIFO_AW-1:0] rp_r;
  logic [FIFO_AW-1:0] rp_nxt;
  logic [LVL_W-1:0] lvl_r;
  logic [LVL_W-1:0] lvl_nxt;
  logic do_push;
  logic do_pop;

  // Pointer and level update; clear wins over any access in the same cycle
  always_comb begin
    do_push = fif.push && (lvl_r != LVL_W'(FIFO_DEPTH));
    do_pop = fif.pop && (lvl_r != '0);
    wp_nxt = wp_r + FIFO_AW'(do_push);
    rp_nxt = rp_r + FIFO_AW'(do_pop);
    lvl_nxt = lvl_r + LVL_W'(do_push) - LVL_W'(do_pop);
    if (fif.clr) begin
      wp_nxt = '0;
      rp_nxt = '0;
      lvl_nxt = '0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
      lvl_r <= '0;
    end else if (ce) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  // Storage has no reset; contents are only visible below the level count
  always_ff @(posedge mclk) begin
    if (ce && do_push && !fif.clr) begin
      mem_a[wp_r] <= fif.push_data;
    end
  end

  assign fif.rd_data = mem_a[rp_r];
  assign fif.level = lvl_r;
endmodule
`default_nettype wire

// >>> tb/ssq_top_props.sv
// Port-level assertion checker for the scan stream sequencer
`timescale 1ns/1ps
`default_nettype none
module ssq_top_props
  import ssq_pkg::*;
#(
  parameter int OVF_TIMEOUT_CYCLES = OVF_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  // Pulse pin and sample source
  input wire logic scan_timing_pulse_pin,
  input wire logic samp_req,
  input wire logic [7:0] samp_chan,
  input wire logic samp_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Register answers come exactly one cycle after the read and then hold
  read_answer_a: assert property (ce |=> reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after read strobe");
  rdata_hold_a: assert property (ce && !reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without an answer");
  // Quiet outputs right after reset release
  reset_idle_a: assert property ($rose(reset_n) |-> scan_timing_pulse_pin && !samp_req)
    else $error("outputs not idle after reset");
  // Pulse pin shape around samples
  sample_pin_a: assert property (samp_req |-> scan_timing_pulse_pin)
    else $error("pulse pin low during a sample");
  sample_lead_a: assert property ($rose(samp_req) |-> !$past(scan_timing_pulse_pin))
    else $error("sample not preceded by a low pulse");
  low_pulse_a: assert property ($fell(scan_timing_pulse_pin) |=> scan_timing_pulse_pin)
    else $error("pulse pin low for more than one cycle");
  sample_end_a: assert property (samp_req && samp_valid && !reg_wr |=> !scan_timing_pulse_pin && !samp_req)
    else $error("sample end did not drop the pin and request");
  // Channel list is walked in order from the first entry
  chan_order_a: assert property (samp_req && samp_valid ##1 !samp_req ##1 samp_req
    |-> samp_chan == $past(samp_chan, 2) + 8'h01)
    else $error("channel did not advance by one");
  chan_hold_a: assert property (samp_req && !samp_valid ##1 samp_req |-> $stable(samp_chan))
    else $error("channel changed while waiting");
  scan_first_a: assert property (!samp_req [*3] ##1 samp_req |-> samp_chan == 8'h00)
    else $error("scan did not start at the first channel");

  // Main scenarios reached
  cover property (samp_req && samp_valid);
  cover property ($fell(scan_timing_pulse_pin));
  cover property (reg_rvalid);
endmodule

bind ssq_top ssq_top_props #(.OVF_TIMEOUT_CYCLES(OVF_TIMEOUT_CYCLES)) i_ssq_top_props (.mclk, .reset_n,
  .ce, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .scan_timing_pulse_pin, .samp_req, .samp_chan,
  .samp_valid);
`default_nettype wire

// >>> tb/ssq_src_model.sv
// Sample source model answering sample requests after a chosen latency
`timescale 1ns/1ps
`default_nettype none
module ssq_src_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Request side
  input wire logic samp_req,
  input wire logic [7:0] samp_chan,
  input wire logic [7:0] lat,
  // Answer side
  output logic samp_valid,
  output logic [15:0] samp_data
);
  logic [7:0] wait_r;
  logic [7:0] seq_r;

  // Answer pulse after lat waiting cycles; data is a moving pattern when not valid
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 8'h00;
      seq_r <= 8'h00;
      samp_valid <= 1'b0;
      samp_data <= 16'h0000;
    end else begin
      seq_r <= seq_r + 8'h01;
      samp_valid <= samp_req && !samp_valid && (wait_r >= lat);
      wait_r <= (samp_req && !samp_valid) ? wait_r + 8'h01 : 8'h00;
      samp_data <= (samp_req && !samp_valid && (wait_r >= lat)) ? {samp_chan, seq_r} : {seq_r, ~seq_r};
    end
  end
endmodule
`default_nettype wire

// >>> tb/scan_stream_sequencer_bench.sv
// Self-checking register-level bench for the scan stream sequencer
`timescale 1ns/1ps
`default_nettype none
module scan_stream_sequencer_bench
  import ssq_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic ext_scan_clock_pin = 1'b0;
  logic [7:0] pin_feature_channel = 8'h00;
  logic [7:0] lat = 8'h00;
  logic scan_timing_pulse_pin, samp_req, samp_valid;
  logic [7:0] samp_chan;
  logic [15:0] samp_data;
  logic [31:0] rv;
  int error_cnt = 0;
  int checked = 0;
  logic [15:0] ra [10] = '{ADDR_FIFO_CAP, ADDR_CLK_SEL, ADDR_BURST, ADDR_EXT_DIV, ADDR_TRIG, ADDR_PERIOD,
    ADDR_NUM_CH, ADDR_EDGE, ADDR_STATUS, 16'h0002};
  logic [31:0] rx [10] = '{RST_CAP, RST_CLK_SEL, RST_BURST, RST_DIV, RST_TRIG, RST_PERIOD,
    {24'h0, RST_NUM_CH}, {30'h0, RST_EDGE}, 32'h0, 32'h0};
  int tch [6] = '{0, 1, 2, 3, 6, 7};

  // Short overflow timeout keeps the run brief
  ssq_top #(.OVF_TIMEOUT_CYCLES(400)) i_ssq_top (.mclk, .reset_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .reg_rvalid, .ext_scan_clock_pin, .pin_feature_channel, .scan_timing_pulse_pin,
    .samp_req, .samp_chan, .samp_valid, .samp_data);
  ssq_src_model i_ssq_src_model (.mclk, .reset_n, .samp_req, .samp_chan, .lat, .samp_valid, .samp_data);

  // 40 MHz clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic stop_test();
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Answer is looked for after the taking edge has settled
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    int n;
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    n = 0;
    #1;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (reg_rvalid !== 1'b1) begin
      chk({31'h0, reg_rvalid}, 32'h1);
      stop_test();
    end
    d = reg_rdata;
  endtask

  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    rd(a, rv);
    chk(rv, e);
  endtask

  // Bounded poll; giving up ends the run
  task automatic poll(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    rd(a, rv);
    while ((rv & m) !== e && n < 400) begin
      rd(a, rv);
      n++;
    end
    chk(rv & m, e);
    if ((rv & m) !== e) stop_test();
  endtask

  task automatic ext_edges(input int n);
    repeat (n) begin
      @(posedge mclk);
      ext_scan_clock_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_scan_clock_pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask

  task automatic setpf(input logic [7:0] v);
    @(posedge mclk);
    pin_feature_channel <= v;
    repeat (4) @(posedge mclk);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values, unmapped read, refused writes
    for (int i = 0; i < 10; i++) rc(ra[i], rx[i]);
    wr(ADDR_FIFO_CAP, 32'h3);
    rc(ADDR_FIFO_CAP, 32'h0);
    wr(ADDR_FIFO_CAP, 32'h0001_0000);
    rc(ADDR_FIFO_CAP, 32'h0);
    // Writes are not taken while the clock enable is low, nor at the read-only skipped counter
    @(posedge mclk) ce <= 1'b0;
    wr(ADDR_FIFO_CAP, 32'h8);
    ce <= 1'b1;
    rc(ADDR_FIFO_CAP, 32'h0);
    wr(ADDR_SKIPPED, 32'h5);
    rc(ADDR_SKIPPED, 32'h0);
    // Burst of two scans over three channels
    wr(ADDR_PERIOD, 32'h20);
    wr(ADDR_NUM_CH, 32'h3);
    wr(ADDR_BURST, 32'h2);
    wr(ADDR_CTL, 32'h1);
    poll(ADDR_STATUS, 32'h1, 32'h0);
    rc(ADDR_BACKLOG, 32'hC);
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_DATA, rv);
      chk(rv >> 8, 32'(i % 3));
    end
    rc(ADDR_DATA, 32'h0);
    // Two-word FIFO overflows, then whole scans resume once drained
    wr(ADDR_FIFO_CAP, 32'h4);
    wr(ADDR_NUM_CH, 32'h1);
    wr(ADDR_PERIOD, 32'h3C);
    wr(ADDR_BURST, 32'h0);
    wr(ADDR_CTL, 32'h1);
    poll(ADDR_STATUS, 32'h4, 32'h4);
    rc(ADDR_BACKLOG, 32'h4);
    rd(ADDR_DATA, rv);
    rd(ADDR_DATA, rv);
    poll(ADDR_BACKLOG, 32'hFFFF_FFFF, 32'h2);
    rc(ADDR_STATUS, 32'h1);
    rc(ADDR_SKIPPED, 32'h1);
    // One-word FIFO left full; a size change mid-session must not help
    wr(ADDR_CTL, 32'h0);
    wr(ADDR_FIFO_CAP, 32'h2);
    wr(ADDR_CTL, 32'h1);
    wr(ADDR_FIFO_CAP, 32'h0);
    poll(ADDR_STATUS, 32'h1, 32'h0);
    rd(ADDR_STATUS, rv);
    chk(rv >> 16, {16'h0, ERR_OVF_TIMEOUT});
    rc(ADDR_BACKLOG, 32'h2);
    rc(ADDR_FIFO_CAP, 32'h0);
    // Slow source lets the next tick land inside a scan
    lat <= 8'h50;
    wr(ADDR_CTL, 32'h1);
    poll(ADDR_STATUS, 32'h1, 32'h0);
    rd(ADDR_STATUS, rv);
    chk(rv >> 16, {16'h0, ERR_OVERLAP});
    rc(ADDR_BACKLOG, 32'h0);
    lat <= 8'h00;
    // External clock divided by three, then a reserved source
    wr(ADDR_CLK_SEL, CLK_SEL_EXT);
    wr(ADDR_EXT_DIV, 32'h3);
    wr(ADDR_CTL, 32'h1);
    ext_edges(5);
    rc(ADDR_BACKLOG, 32'h2);
    ext_edges(1);
    rc(ADDR_BACKLOG, 32'h4);
    wr(ADDR_CTL, 32'h0);
    wr(ADDR_CLK_SEL, 32'h1);
    wr(ADDR_CTL, 32'h1);
    ext_edges(4);
    rc(ADDR_BACKLOG, 32'h0);
    wr(ADDR_CTL, 32'h0);
    wr(ADDR_CLK_SEL, CLK_SEL_INT);
    // Falling-edge trigger ignores a rising edge
    wr(ADDR_EDGE, {30'h0, EDGE_FALL});
    wr(ADDR_TRIG, TRIG_BASE + 32'h3);
    wr(ADDR_CTL, 32'h1);
    setpf(8'h08);
    rc(ADDR_STATUS, 32'h3);
    setpf(8'h00);
    rc(ADDR_STATUS, 32'h1);
    setpf(8'h08);
    setpf(8'h00);
    rc(ADDR_STATUS, 32'h1);
    // Every channel trigger code, rising or either edge
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CTL, 32'h0);
      wr(ADDR_EDGE, {30'h0, (i % 2 == 1) ? EDGE_BOTH : EDGE_RISE});
      wr(ADDR_TRIG, TRIG_BASE + 32'(tch[i]));
      wr(ADDR_CTL, 32'h1);
      rc(ADDR_STATUS, 32'h3);
      setpf(8'h01 << tch[i]);
      rc(ADDR_STATUS, 32'h1);
      setpf(8'h00);
    end
    // Channel four is not a trigger source, so its edge must not start scanning
    wr(ADDR_CTL, 32'h0);
    wr(ADDR_TRIG, TRIG_BASE + 32'h4);
    wr(ADDR_CTL, 32'h1);
    setpf(8'h10);
    rc(ADDR_STATUS, 32'h3);
    stop_test();
  end
endmodule
`default_nettype wire
